// *** src/pss_defs.vh ***
`ifndef PSS_DEFS_VH
`define PSS_DEFS_VH
// ****************************************
// wishbone register map (byte addresses, byte = 4*index)
// ****************************************
`define PSS_ADDR_CTRL      8'h00
`define PSS_ADDR_STATUS    8'h04
`define PSS_ADDR_SEQCFG    8'h08
`define PSS_ADDR_SLOTA     8'h0c
`define PSS_ADDR_SLOTB     8'h10
`define PSS_ADDR_EVENTS    8'h14
`define PSS_ADDR_WAKECFG   8'h18
`define PSS_ADDR_FAULT     8'h1c
// ctrl fields
`define PSS_CTRL_AUTO_BOOT 0
`define PSS_CTRL_SYSTEM_DOMAIN_ENABLE    1
`define PSS_CTRL_RELOAD    2
`define PSS_CTRL_DEFSUP    3
`define PSS_CTRL_RDYSEL    4
`define PSS_CTRL_BLINK_LO  8
`define PSS_CTRL_RESET     32'h0000_0011
// fault fields
`define PSS_FAULT_WEAK     0
`define PSS_FAULT_POR      1
// seqcfg fields: [3:0] step code, [7:4] sys end, [11:8] power end, [15:12] max count
`define PSS_SEQCFG_RESET   32'h0000_e849
// slots: 4 bits per id, 8 ids in slota, 6 ids in slotb
`define PSS_SLOTA_RESET    32'h0000_0000
`define PSS_SLOTB_RESET    32'h0000_0000
`define PSS_NUM_IDS        14
// timing, 50 mhz clock
`define PSS_CLK_HZ         50000000
`define PSS_DEBOUNCE_US    10000
`define PSS_RISE_TMO_US    128000
`define PSS_WEAK_WIN_US    10000000
`define PSS_DOMAIN_GAP_US  32
`define PSS_BASE_STEP_US   32
`define PSS_DEBOUNCE_CYC   (`PSS_DEBOUNCE_US * (`PSS_CLK_HZ / 1000000))
`define PSS_RISE_TMO_CYC   (`PSS_RISE_TMO_US * (`PSS_CLK_HZ / 1000000))
`define PSS_WEAK_WIN_CYC   (`PSS_WEAK_WIN_US * (`PSS_CLK_HZ / 1000000))
`define PSS_GAP_CYC        (`PSS_DOMAIN_GAP_US * (`PSS_CLK_HZ / 1000000))
`define PSS_BASE_STEP_CYC  (`PSS_BASE_STEP_US * (`PSS_CLK_HZ / 1000000))
`define PSS_RELOAD_CYC     8
`endif

// *** src/pss_sequencer.v ***
// Implementation choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`include "pss_defs.vh"
module pss_sequencer #(
  parameter [31:0] DEBOUNCE_CYC = `PSS_DEBOUNCE_CYC,
  parameter [31:0] RISE_TMO_CYC = `PSS_RISE_TMO_CYC,
  parameter [31:0] WEAK_WIN_CYC = `PSS_WEAK_WIN_CYC
) (
  input  wire        clk_i,
  input  wire        rst_n_i,
  input  wire        core_rail_good_i,
  input  wire        charger_input_detect_i,
  input  wire        charger_above_threshold_i,
  input  wire        headroom_comparator_i,
  input  wire        system_rail_min_i,
  input  wire        battery_good_i,
  input  wire        battery_low_i,
  input  wire        battery_charged_i,
  input  wire        undervoltage_i,
  input  wire        system_domain_enable_i,
  input  wire [13:0] wake_events_i,
  input  wire [8:0]  gpi_event_i,
  input  wire [31:0] wb_adr_i,
  input  wire [31:0] wb_dat_i,
  input  wire [3:0]  wb_sel_i,
  input  wire        wb_we_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output reg         internal_por_n_o,
  output reg         core_regulator_en_o,
  output reg         charger_en_o,
  output reg         trim_load_o,
  output reg         charger_buck_en_o,
  output reg         config_reload_o,
  output reg  [13:0] supply_en_o,
  output reg         ready_o,
  output reg         host_wake_signal_o,
  output reg         host_reset_n_o,
  output reg         calendar_clear_o,
  output reg         blink_en_o,
  output reg  [13:0] irq_events_o
);
  // ****************************************
  // states
  // ****************************************
  localparam [9:0] S_NOPWR = 10'h001, S_RESET = 10'h002, S_DEBNC = 10'h004,
                   S_RISE  = 10'h008, S_PDOWN = 10'h010, S_RELD  = 10'h020,
                   S_STEP0 = 10'h040, S_GAP   = 10'h080, S_SLOT  = 10'h100,
                   S_DONE  = 10'h200;
  // event bit positions; bits 4,8,9 are seq done, temp, adc
  localparam [13:0] WAKE_MASK = 14'h3cef;
  localparam [13:0] USER_MASK = 14'h0060;

  // ****************************************
  // input synchronisers
  // ****************************************
  wire [10:0] raw_w = {undervoltage_i, battery_charged_i, battery_low_i, battery_good_i,
                       system_domain_enable_i, system_rail_min_i, headroom_comparator_i,
                       charger_above_threshold_i, charger_input_detect_i, core_rail_good_i, 1'b0};
  reg  [10:0] sy1_reg, sy2_reg;
  reg  [13:0] ev1_reg, ev2_reg;
  reg  [8:0]  gp1_reg, gp2_reg;
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      sy1_reg <= 11'h000;
      sy2_reg <= 11'h000;
      ev1_reg <= 14'h0000;
      ev2_reg <= 14'h0000;
      gp1_reg <= 9'h000;
      gp2_reg <= 9'h000;
    end else begin
      sy1_reg <= raw_w;
      sy2_reg <= sy1_reg;
      ev1_reg <= wake_events_i;
      ev2_reg <= ev1_reg;
      gp1_reg <= gpi_event_i;
      gp2_reg <= gp1_reg;
    end
  end
  wire core_ok = sy2_reg[1], vbus = sy2_reg[2], vch = sy2_reg[3], hdrm = sy2_reg[4];
  wire rail_min = sy2_reg[5], system_domain_enable_pin = sy2_reg[6], bat_good = sy2_reg[7];
  wire bat_low = sy2_reg[8], bat_full = sy2_reg[9], uv = sy2_reg[10];
  reg  vbus_d_reg;

  // ****************************************
  // registers
  // ****************************************
  reg [31:0] ctrl_reg, seqcfg_reg, slota_reg, slotb_reg, wakecfg_reg;
  reg [1:0]  fault_reg;
  reg        emerg_reg;
  reg [9:0]  state_reg;
  reg [3:0]  step_reg;
  reg [31:0] cnt_reg;
  reg [31:0] weak_cnt_reg;
  reg        weak_run_reg;
  reg        from_reset_reg;
  wire [3:0] sys_end = seqcfg_reg[7:4];
  wire [3:0] step_code = seqcfg_reg[3:0];
  wire       system_domain_enable = system_domain_enable_pin | ctrl_reg[`PSS_CTRL_SYSTEM_DOMAIN_ENABLE];
  wire       auto_boot = ctrl_reg[`PSS_CTRL_AUTO_BOOT] & ~emerg_reg;

  // per-id slot lookup and match
  wire [55:0] slots_w = {slotb_reg[23:0], slota_reg};
  wire [13:0] slot_hit;
  genvar gi;
  generate
    for (gi = 0; gi < `PSS_NUM_IDS; gi = gi + 1) begin : g_id
      // ids mapped to slot 0 or unmapped never match a running step
      assign slot_hit[gi] = (slots_w[gi*4 +: 4] == step_reg) && (step_reg != 4'h0);
    end
  endgenerate

  // wake qualification: gpi needs mode and unmasked interrupt
  wire       gpi_wake = |(gp2_reg & wakecfg_reg[8:0] & ~wakecfg_reg[24:16]);
  wire [13:0] wake_src = ev2_reg & WAKE_MASK & (emerg_reg ? USER_MASK : 14'h3fff);
  wire       wake = (|wake_src) | (gpi_wake & (1'b1));

  // step interval doubles with every second code step from the base (code bits [3:1])
  wire [31:0] step_cyc = `PSS_BASE_STEP_CYC << step_code[3:1];

  // ****************************************
  // bus slave: single-cycle ack, dropped after one cycle
  // ****************************************
  wire       wb_go = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire       wb_wr = wb_go & wb_we_i & wb_sel_i[0];
  wire [7:0] adr = wb_adr_i[7:0];
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_go;
      if (wb_go) begin
        case (adr)
          `PSS_ADDR_CTRL:    wb_dat_o <= ctrl_reg;
          `PSS_ADDR_STATUS:  wb_dat_o <= {14'h0000, emerg_reg, ready_o, step_reg, 2'h0, state_reg};
          `PSS_ADDR_SEQCFG:  wb_dat_o <= seqcfg_reg;
          `PSS_ADDR_SLOTA:   wb_dat_o <= slota_reg;
          `PSS_ADDR_SLOTB:   wb_dat_o <= slotb_reg;
          `PSS_ADDR_EVENTS:  wb_dat_o <= {18'h00000, irq_events_o};
          `PSS_ADDR_WAKECFG: wb_dat_o <= wakecfg_reg;
          `PSS_ADDR_FAULT:   wb_dat_o <= {30'h0000_0000, fault_reg};
          default:           wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************
  // main state machine
  // ****************************************
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg <= S_NOPWR;
      step_reg <= 4'h0;
      cnt_reg <= 32'h0000_0000;
      ctrl_reg <= `PSS_CTRL_RESET;
      seqcfg_reg <= `PSS_SEQCFG_RESET;
      slota_reg <= `PSS_SLOTA_RESET;
      slotb_reg <= `PSS_SLOTB_RESET;
      wakecfg_reg <= 32'h0000_0000;
      fault_reg <= 2'h0;
      emerg_reg <= 1'b0;
      weak_cnt_reg <= 32'h0000_0000;
      weak_run_reg <= 1'b0;
      from_reset_reg <= 1'b0;
      vbus_d_reg <= 1'b0;
      internal_por_n_o <= 1'b0;
      core_regulator_en_o <= 1'b0;
      charger_en_o <= 1'b0;
      trim_load_o <= 1'b0;
      charger_buck_en_o <= 1'b0;
      config_reload_o <= 1'b0;
      supply_en_o <= 14'h0000;
      ready_o <= 1'b0;
      host_wake_signal_o <= 1'b0;
      host_reset_n_o <= 1'b0;
      calendar_clear_o <= 1'b0;
      blink_en_o <= 1'b0;
      irq_events_o <= 14'h0000;
    end else begin
      vbus_d_reg <= vbus;
      trim_load_o <= 1'b0;
      config_reload_o <= 1'b0;
      calendar_clear_o <= 1'b0;
      // sticky event record, set wins over write-one-clear
      irq_events_o <= (irq_events_o & ~((wb_wr && adr == `PSS_ADDR_EVENTS) ? wb_dat_i[13:0] : 14'h0000))
                      | ev2_reg;
      if (wb_wr) begin
        case (adr)
          `PSS_ADDR_CTRL:    ctrl_reg <= wb_dat_i;
          `PSS_ADDR_SEQCFG:  seqcfg_reg <= wb_dat_i;
          `PSS_ADDR_SLOTA:   slota_reg <= wb_dat_i;
          `PSS_ADDR_SLOTB:   slotb_reg <= wb_dat_i;
          `PSS_ADDR_WAKECFG: wakecfg_reg <= wb_dat_i;
          default: ;
        endcase
      end
      // clear first, so a weak-start set in the same cycle wins
      if (wb_wr && adr == `PSS_ADDR_FAULT)
        fault_reg <= fault_reg & ~wb_dat_i[1:0];
      // weak-start window after host reset release
      if (weak_run_reg) begin
        if (uv && weak_cnt_reg < WEAK_WIN_CYC) begin
          fault_reg[`PSS_FAULT_WEAK] <= 1'b1;
          emerg_reg <= 1'b1;
        end
        weak_cnt_reg <= weak_cnt_reg + 32'h0000_0001;
        if (weak_cnt_reg >= WEAK_WIN_CYC) weak_run_reg <= 1'b0;
      end
      if (emerg_reg && bat_full) emerg_reg <= 1'b0;
      blink_en_o <= emerg_reg & (ctrl_reg[11:8] != 4'h0);
      if (!core_ok && state_reg != S_NOPWR) begin
        // core rail collapse: back to no-power with power, charger and host outputs off
        state_reg <= S_NOPWR;
        internal_por_n_o <= 1'b0;
        core_regulator_en_o <= 1'b0;
        charger_en_o <= 1'b0;
        charger_buck_en_o <= 1'b0;
        supply_en_o <= 14'h0000;
        ready_o <= 1'b0;
        host_reset_n_o <= 1'b0;
        host_wake_signal_o <= 1'b0;
      // undervoltage forces reset mode from any powered state
      end else if (uv && state_reg != S_NOPWR && state_reg != S_RESET) begin
        state_reg <= S_RESET; supply_en_o <= 14'h0000; ready_o <= 1'b0;
        host_reset_n_o <= 1'b0; charger_buck_en_o <= 1'b0;
      end else begin
        case (state_reg)
          S_NOPWR: begin
            internal_por_n_o <= 1'b0;
            if (core_ok) begin
              internal_por_n_o <= 1'b1; core_regulator_en_o <= 1'b1;
              calendar_clear_o <= 1'b1; fault_reg <= 2'h0;
              state_reg <= S_RESET;
            end
          end
          S_RESET: begin
            host_reset_n_o <= 1'b0; host_wake_signal_o <= 1'b0;
            cnt_reg <= 32'h0000_0000;
            if (vbus && !vbus_d_reg && (bat_low || emerg_reg)) begin
              charger_en_o <= 1'b1; trim_load_o <= 1'b1;
              state_reg <= S_DEBNC;
            end else if (bat_good && !bat_low) begin
              trim_load_o <= 1'b1; state_reg <= S_RISE;
            end
          end
          S_DEBNC: begin
            cnt_reg <= cnt_reg + 32'h0000_0001;
            if (cnt_reg >= DEBOUNCE_CYC - 32'h0000_0001) begin
              cnt_reg <= 32'h0000_0000;
              if (!vch) begin
                charger_en_o <= 1'b0; state_reg <= S_RESET;
              end else if (hdrm) begin
                charger_buck_en_o <= 1'b1; state_reg <= S_RISE;
              end
            end
          end
          S_RISE: begin
            cnt_reg <= cnt_reg + 32'h0000_0001;
            if (rail_min || bat_good) begin
              from_reset_reg <= 1'b1; state_reg <= S_PDOWN;
            end else if (cnt_reg >= RISE_TMO_CYC - 32'h0000_0001) begin
              charger_buck_en_o <= 1'b0; state_reg <= S_RESET;
            end
          end
          S_PDOWN: begin
            cnt_reg <= 32'h0000_0000;
            if (from_reset_reg && auto_boot && !emerg_reg) begin
              host_wake_signal_o <= 1'b1;
              from_reset_reg <= 1'b0;
              if (system_domain_enable) state_reg <= S_RELD;
            end else if (system_domain_enable && (auto_boot || wake)) begin
              from_reset_reg <= 1'b0; state_reg <= S_RELD;
            end
          end
          S_RELD: begin
            // supply and timer config reloaded before any step runs
            config_reload_o <= (ctrl_reg[`PSS_CTRL_RELOAD] | ~from_reset_reg);
            cnt_reg <= cnt_reg + 32'h0000_0001;
            if (cnt_reg >= `PSS_RELOAD_CYC) begin
              cnt_reg <= 32'h0000_0000; step_reg <= 4'h0; state_reg <= S_STEP0;
            end
          end
          S_STEP0: begin
            if (ctrl_reg[`PSS_CTRL_DEFSUP]) supply_en_o <= supply_en_o | slotb_reg[31:18];
            if (system_domain_enable) begin
              ready_o <= ctrl_reg[`PSS_CTRL_RDYSEL];
              state_reg <= S_GAP;
            end
          end
          S_GAP: begin
            cnt_reg <= cnt_reg + 32'h0000_0001;
            if (cnt_reg >= `PSS_GAP_CYC - 1) begin
              cnt_reg <= 32'h0000_0000;
              if (step_reg == sys_end) begin
                ready_o <= 1'b0; irq_events_o[4] <= 1'b1;
                host_reset_n_o <= 1'b1; host_wake_signal_o <= 1'b0;
                weak_run_reg <= 1'b1; weak_cnt_reg <= 32'h0000_0000;
                state_reg <= S_DONE;
              end else begin
                step_reg <= step_reg + 4'h1; state_reg <= S_SLOT;
              end
            end
          end
          S_SLOT: begin
            if (cnt_reg == 32'h0000_0000) supply_en_o <= supply_en_o | slot_hit;
            cnt_reg <= cnt_reg + 32'h0000_0001;
            if (cnt_reg >= step_cyc - 32'h0000_0001) begin
              cnt_reg <= 32'h0000_0000;
              if (step_reg == sys_end) state_reg <= S_GAP;
              else step_reg <= step_reg + 4'h1;
            end
          end
          S_DONE: begin
            if (!system_domain_enable) begin
              supply_en_o <= 14'h0000; step_reg <= 4'h0; state_reg <= S_PDOWN;
            end
          end
          default: state_reg <= S_RESET;
        endcase
      end
    end
  end
endmodule

// *** test/pss_host_model.sv ***
`timescale 1ns/1ps
// ****************************************
// charger supply and host processor
// ****************************************
module pss_host_model (
  input  wire       clk_i,
  input  wire       rst_n_i,
  input  wire       charger_buck_en_i,
  input  wire       charger_present_i,
  input  wire       host_wake_i,
  input  wire       sys_req_i,
  input  wire [7:0] rail_dly_i,
  output reg        system_rail_min_o,
  output wire       headroom_o,
  output wire       system_domain_enable_o
);
  reg [7:0] rise_cnt_reg;
  // rail only charges while the buck feeds it; a slow delay stresses the timeout
  always @(posedge clk_i) begin
    if (!rst_n_i || !charger_buck_en_i) begin
      rise_cnt_reg <= 8'h00;
      system_rail_min_o <= 1'h0;
    end else if (rise_cnt_reg == rail_dly_i) begin
      system_rail_min_o <= 1'h1;
    end else begin
      rise_cnt_reg <= rise_cnt_reg + 8'h01;
    end
  end
  assign headroom_o = charger_present_i;
  assign system_domain_enable_o = sys_req_i | host_wake_i;
endmodule

// *** test/pss_sequencer_sva.sv ***
`timescale 1ns/1ps
// ****************************************
// sequencer port checks
// ****************************************
module pss_sequencer_sva #(
  parameter [31:0] RISE_TMO_CYC = 32'd50
) (
  input  wire        clk_i,
  input  wire        rst_n_i,
  input  wire        core_rail_good_i,
  input  wire        system_rail_min_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_ack_o,
  input  wire        internal_por_n_o,
  input  wire        charger_en_o,
  input  wire        charger_buck_en_o,
  input  wire        trim_load_o,
  input  wire        calendar_clear_o,
  input  wire        host_reset_n_o,
  input  wire [13:0] supply_en_o
);
  reg [31:0] rise_cnt_reg;
  // slack of 8 cycles covers the input synchronisers
  always @(posedge clk_i) begin
    if (!rst_n_i || !charger_buck_en_o || system_rail_min_i) begin
      rise_cnt_reg <= 32'h0;
    end else begin
      rise_cnt_reg <= rise_cnt_reg + 32'h1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  ack_one_cycle_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged after one cycle");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  por_hold_a: assert property (!core_rail_good_i [*4] |-> !internal_por_n_o)
    else $error("power-on reset released while core rail low");
  off_in_por_a: assert property (!internal_por_n_o |-> supply_en_o == 14'h0 && !charger_buck_en_o && !host_reset_n_o)
    else $error("outputs active during power-on reset");
  buck_needs_chg_a: assert property (charger_buck_en_o |-> charger_en_o)
    else $error("charger buck on with charger off");
  trim_pulse_a: assert property (trim_load_o |=> !trim_load_o) else $error("trim load not a pulse");
  clear_pulse_a: assert property (calendar_clear_o |=> !calendar_clear_o) else $error("clear not a pulse");
  rise_limit_a: assert property (rise_cnt_reg <= RISE_TMO_CYC + 32'd8)
    else $error("rail rise wait exceeds timeout");
  cover property (wb_ack_o);
  cover property ($rose(charger_buck_en_o));
  cover property ($rose(host_reset_n_o));
endmodule
bind pss_sequencer pss_sequencer_sva #(.RISE_TMO_CYC(RISE_TMO_CYC)) u_sva (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .core_rail_good_i(core_rail_good_i), .system_rail_min_i(system_rail_min_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .internal_por_n_o(internal_por_n_o),
  .charger_en_o(charger_en_o), .charger_buck_en_o(charger_buck_en_o), .trim_load_o(trim_load_o),
  .calendar_clear_o(calendar_clear_o), .host_reset_n_o(host_reset_n_o), .supply_en_o(supply_en_o));

// *** test/test_pss_sequencer.sv ***
`timescale 1ns/1ps
`include "pss_defs.vh"
module test_pss_sequencer;
  localparam [31:0] DEB = 32'd20;
  reg         clk_i;
  reg         rst_n_i = 1'h0;
  reg         rail_good = 1'h0;
  reg         chg_det = 1'h0;
  reg         chg_thr = 1'h0;
  reg         uv = 1'h0;
  reg         sys_req = 1'h0;
  reg         we = 1'h0;
  reg         cyc = 1'h0;
  reg         stb = 1'h0;
  reg  [3:0]  sel = 4'h0;
  reg  [13:0] wake_ev = 14'h0;
  reg  [8:0]  gpi = 9'h000;
  reg         bat_full = 1'h0;
  wire        blink;
  reg  [31:0] adr = 32'h0;
  reg  [31:0] wdat = 32'h0;
  reg  [31:0] rd;
  wire [31:0] rdat;
  wire        ack, por_n, core_en, chg_en, buck_en, rail_min, headroom, system_domain_enable, host_wake, host_rst_n, ready;
  wire [13:0] supply_en, irq;
  integer     miscompares = 0;
  integer     checks_done = 0;
  integer     cycles = 0;
  integer     n;
  pss_sequencer #(.DEBOUNCE_CYC(DEB), .RISE_TMO_CYC(32'd50), .WEAK_WIN_CYC(32'd100)) dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .core_rail_good_i(rail_good), .charger_input_detect_i(chg_det),
    .charger_above_threshold_i(chg_thr), .headroom_comparator_i(headroom), .system_rail_min_i(rail_min),
    .battery_good_i(1'h0), .battery_low_i(1'h1), .battery_charged_i(bat_full), .undervoltage_i(uv),
    .system_domain_enable_i(system_domain_enable), .wake_events_i(wake_ev), .gpi_event_i(gpi), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat),
    .wb_ack_o(ack), .internal_por_n_o(por_n), .core_regulator_en_o(core_en), .charger_en_o(chg_en),
    .trim_load_o(), .charger_buck_en_o(buck_en), .config_reload_o(), .supply_en_o(supply_en), .ready_o(ready),
    .host_wake_signal_o(host_wake), .host_reset_n_o(host_rst_n), .calendar_clear_o(), .blink_en_o(blink),
    .irq_events_o(irq));
  pss_host_model host (.clk_i(clk_i), .rst_n_i(rst_n_i), .charger_buck_en_i(buck_en), .charger_present_i(chg_thr),
    .host_wake_i(host_wake), .sys_req_i(sys_req), .rail_dly_i(8'h1e), .system_rail_min_o(rail_min),
    .headroom_o(headroom), .system_domain_enable_o(system_domain_enable));
  initial begin
    clk_i = 1'h0;
    forever #10 clk_i = ~clk_i;
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED at %0t: seen %h, expected %h", $time, got, exp);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("comparisons %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      miscompares = miscompares + 1;
      report_and_stop;
    end
  end
  task wb(input [31:0] a, input w, input [31:0] d);
    begin
      @(posedge clk_i);
      adr <= a;
      we <= w;
      wdat <= d;
      sel <= 4'hf;
      cyc <= 1'h1;
      stb <= 1'h1;
      @(posedge clk_i);
      while (ack !== 1'h1) @(posedge clk_i);
      rd = rdat;
      cyc <= 1'h0;
      stb <= 1'h0;
      we <= 1'h0;
    end
  endtask
  task rdchk(input [31:0] a, input [31:0] exp);
    begin
      wb(a, 1'h0, 32'h0);
      chk(rd, exp);
    end
  endtask
  task t_por;
    begin
      repeat (6) @(posedge clk_i);
      chk(por_n, 1'h0);
      rail_good <= 1'h1;
      for (n = 0; n < 12 && por_n !== 1'h1; n = n + 1) @(posedge clk_i);
      chk(por_n, 1'h1);
      repeat (2) @(posedge clk_i);
      chk(core_en, 1'h1);
      wb(`PSS_ADDR_FAULT, 1'h0, 32'h0);
      chk(rd[0], 1'h0);
    end
  endtask
  task t_regs;
    begin
      rdchk(`PSS_ADDR_CTRL, `PSS_CTRL_RESET);
      rdchk(`PSS_ADDR_SEQCFG, `PSS_SEQCFG_RESET);
      rdchk(`PSS_ADDR_SLOTA, `PSS_SLOTA_RESET);
      wb(32'h20, 1'h1, 32'hffff_ffff);
      rdchk(32'h20, 32'h0);
      wb(`PSS_ADDR_SEQCFG, 1'h1, 32'h0000_e840);
      rdchk(`PSS_ADDR_SEQCFG, 32'h0000_e840);
      wb(`PSS_ADDR_CTRL, 1'h1, 32'h0000_0010);
      rdchk(`PSS_ADDR_CTRL, 32'h0000_0010);
    end
  endtask
  task t_nochg;
    begin
      chg_det <= 1'h1;
      for (n = 0; n < 12 && chg_en !== 1'h1; n = n + 1) @(posedge clk_i);
      chk(chg_en, 1'h1);
      repeat (DEB + 10) @(posedge clk_i);
      chk(buck_en, 1'h0);
      chk(chg_en, 1'h0);
      chg_det <= 1'h0;
      repeat (10) @(posedge clk_i);
    end
  endtask
  task t_start;
    begin
      chg_thr <= 1'h1;
      chg_det <= 1'h1;
      for (n = 0; n < DEB + 20 && buck_en !== 1'h1; n = n + 1) @(posedge clk_i);
      chk(buck_en, 1'h1);
      repeat (80) @(posedge clk_i);
      chk(buck_en, 1'h1);
      chk(host_wake, 1'h0);
      chk(supply_en, 14'h0);
    end
  endtask
  task t_events;
    integer i;
    begin
      // ids 0,1 in slot 1, id 2 in slot 3, id 3 past the system end
      wb(`PSS_ADDR_SLOTA, 1'h1, 32'h0000_5311);
      wb(`PSS_ADDR_EVENTS, 1'h1, 32'h0000_3fff);
      sys_req <= 1'h1;
      wake_ev <= 14'h0310;
      repeat (4) @(posedge clk_i);
      wake_ev <= 14'h0;
      repeat (40) @(posedge clk_i);
      chk(irq & 14'h0310, 14'h0310);
      chk(ready, 1'h0);
      wb(`PSS_ADDR_EVENTS, 1'h1, 32'h0000_3fff);
      wake_ev <= 14'h0020;
      repeat (4) @(posedge clk_i);
      wake_ev <= 14'h0;
      for (n = 0; n < 4000 && ready !== 1'h1; n = n + 1) @(posedge clk_i);
      chk(ready, 1'h1);
      chk(irq[5], 1'h1);
      for (n = 0; n < 30000 && irq[4] !== 1'h1; n = n + 1) @(posedge clk_i);
      chk(irq[4], 1'h1);
      chk(ready, 1'h0);
      chk(supply_en, 14'h0007);
      for (i = 0; i < 14; i = i + 1) begin
        wake_ev <= 14'h1 << i;
        repeat (4) @(posedge clk_i);
      end
      wake_ev <= 14'h0;
      repeat (10) @(posedge clk_i);
      chk(irq, 14'h3fff);
    end
  endtask
  task t_weak;
    begin
      for (n = 0; n < 2000 && host_rst_n !== 1'h1; n = n + 1) @(posedge clk_i);
      chk(host_rst_n, 1'h1);
      uv <= 1'h1;
      repeat (6) @(posedge clk_i);
      uv <= 1'h0;
      repeat (20) @(posedge clk_i);
      wb(`PSS_ADDR_FAULT, 1'h0, 32'h0);
      chk(rd[0], 1'h1);
    end
  endtask
  task t_emerg;
    begin
      wb(`PSS_ADDR_CTRL, 1'h1, 32'h0000_0111);
      wb(`PSS_ADDR_WAKECFG, 1'h1, 32'h0001_0001);
      chg_det <= 1'h0;
      repeat (6) @(posedge clk_i);
      chg_det <= 1'h1;
      repeat (100) @(posedge clk_i);
      chk(host_wake, 1'h0);
      chk(blink, 1'h1);
      // system event plus a masked gpi: neither may wake
      wake_ev <= 14'h0001;
      gpi <= 9'h001;
      repeat (4) @(posedge clk_i);
      wake_ev <= 14'h0;
      gpi <= 9'h000;
      repeat (20) @(posedge clk_i);
      chk(ready, 1'h0);
      wb(`PSS_ADDR_WAKECFG, 1'h1, 32'h0000_0001);
      gpi <= 9'h001;
      for (n = 0; n < 100 && ready !== 1'h1; n = n + 1) @(posedge clk_i);
      gpi <= 9'h000;
      chk(ready, 1'h1);
      bat_full <= 1'h1;
      repeat (6) @(posedge clk_i);
      chk(blink, 1'h0);
      wb(`PSS_ADDR_STATUS, 1'h0, 32'h0);
      chk(rd[17], 1'h0);
    end
  endtask
  task t_drop;
    begin
      rail_good <= 1'h0;
      repeat (6) @(posedge clk_i);
      chk(por_n, 1'h0);
      chk(core_en, 1'h0);
    end
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'h1;
    t_por;
    t_regs;
    t_nochg;
    t_start;
    t_events;
    t_weak;
    t_emerg;
    t_drop;
    report_and_stop;
  end
endmodule
